//--- src/rst_clk_pkg.sv
// Constants, register map and carrier types for the reset and clock start-up
// block. Assumes a 100 MHz core clock and a classic Wishbone register bus.
package rst_clk_pkg;

  // Register word offsets (byte addresses).
  localparam logic [3:0] trim_off = 4'h0;
  localparam logic [3:0] cfg_off = 4'h4;
  localparam logic [3:0] status_off = 4'h8;
  localparam logic [3:0] cal_off = 4'hc;

  // Trim register fields and reset value.
  localparam int fine_lsb = 4;
  localparam int coarse_fast_bit = 3;
  localparam int coarse_slow_bit = 2;
  localparam logic [7:0] trim_reset = 8'h70;
  localparam logic [7:0] trim_impl_mask = 8'hfc;

  // Configuration register fields (programming-time word image).
  localparam int osc_sel_lsb = 0;
  localparam int powerup_timer_en_bit = 4;
  localparam logic [4:0] cfg_reset = 5'h1d;

  // Timing.
  localparam int clk_mhz = 100;
  localparam int powerup_timer_ms = 72;
  localparam int powerup_timer_cycles = powerup_timer_ms * 1000 * clk_mhz;
  localparam int ost_cycles = 1024;
  localparam int filt_cycles = 4;
  localparam int sys_div = 4;

  // Oscillator selections.
  typedef enum logic [2:0] {
    osc_lp = 3'b000,
    osc_xt = 3'b001,
    osc_hs = 3'b010,
    osc_bad = 3'b011,
    osc_irc_io = 3'b100,
    osc_irc_clk = 3'b101,
    osc_erc_io = 3'b110,
    osc_erc_clk = 3'b111
  } osc_sel_t;

  // Reset causes.
  typedef enum logic [2:0] {
    cause_por = 3'b000,
    cause_master_clear_n_run = 3'b001,
    cause_master_clear_n_sleep = 3'b010,
    cause_wdt_run = 3'b011,
    cause_wdt_wake = 3'b100
  } cause_t;

  // Oscillator pin drive group.
  typedef struct packed {
    logic out_o;
    logic oe;
  } pin_drv_t;

  // Clock-out pin and crystal modes decoded from the selection.
  function automatic logic osc_is_divided_clock_output(input logic [2:0] s);
    return (s == osc_irc_clk) || (s == osc_erc_clk);
  endfunction

  function automatic logic osc_is_crystal(input logic [2:0] s);
    return (s == osc_lp) || (s == osc_xt) || (s == osc_hs);
  endfunction

endpackage

//--- src/reset_and_clock_startup.sv
// Reset sequencer, reset-cause tracking, master-clear filter, oscillator trim
// register and divided clock output, all in one clock domain.
// Assumes the power-on detector, watchdog and sleep state arrive as pins.
//
// Notes on behaviour
// [RULE_01] Upper trim nibble raises RC frequency stepwise from 0000 to 1111.
// [RULE_02] Bit 3 gives a coarse speed-up, bit 2 a coarse slow-down.
// [RULE_03] Software writes zeros to trim bits 1 and 0.
// [RULE_04] Factory calibration word is readable for software to copy into trim.
// [RULE_05] Internal RC mode gives a nominal 4 MHz system clock.
// [RULE_06] Clock output on second oscillator pin only for selections 101, 111.
// [RULE_07] Clock output toggles at oscillator frequency divided by four.
// [RULE_08] Power-on, master-clear run, master-clear sleep, watchdog resets told apart.
// [RULE_09] Unaffected registers keep contents through all non-power-on resets.
// [RULE_10] Reset-state registers load on all resets except watchdog wake-up.
// [RULE_11] Master-clear input filter ignores short pulses.
// [RULE_12] Watchdog reset never drives the master-clear pin.
// [RULE_13] Under master clear, second pin low in clock-out modes, input else.
// [RULE_14] Under master clear, first pin is a tri-stated input in RC modes.
// [RULE_15] Power-on detect holds the chip in reset until supply is good.
// [RULE_16] Power-up timer holds reset 72 ms from power-on, only on power-up.
// [RULE_17] Power-up timer runs from its own oscillator, not the system clock.
// [RULE_18] Power-up timer enabled by a programming-time configuration bit.
// [RULE_19] Start-up timer adds 1024 first-pin cycles after the power-up delay.
// [RULE_20] Start-up timer only in crystal modes, after power-on or wake-up.
// [RULE_21] Enable bit is inverted: one disables the power-up timer.
// [RULE_22] Selection decode: 111,110 ext RC; 101,100 int RC; 011 bad; crystals.
// [RULE_23] Core leaves reset when filtered pin is high and timers expired.
`timescale 1ns/100ps
`default_nettype none

module reset_and_clock_startup
  import rst_clk_pkg::*;
#(
  parameter int powerup_timer_count = powerup_timer_cycles,
  parameter int ost_count = ost_cycles,
  parameter logic [7:0] cal_value = 8'h5a // Arbitrary factory value.
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Reset sources, sleep state and timer clock.
  input wire logic por_i,
  input wire logic master_clear_n_i,
  input wire logic wdt_timeout_i,
  input wire logic sleeping_i,
  input wire logic timer_rc_i,
  // Oscillator pins.
  input wire logic osc_pin_in_i,
  output logic osc_pin_in_oe_o,
  output logic osc_pin_out_o,
  output logic osc_pin_out_oe_o,
  // Core controls.
  output logic core_reset_o,
  output logic [7:0] trim_o,
  output logic wake_resume_o
);

  typedef enum logic [2:0] {
    st_por = 3'b000,
    st_powerup_timer = 3'b001,
    st_ost = 3'b010,
    st_hold = 3'b011,
    st_run = 3'b100
  } seq_t;

  // Three-stage synchronisers for the asynchronous pins.
  logic [2:0] master_clear_n_sync_reg;
  logic [2:0] rc_sync_reg;
  logic [2:0] osc_sync_reg;
  logic [2:0] por_sync_reg;
  logic [2:0] wdt_sync_reg;

  // Each asynchronous pin passes three flip-flops before use.
  always_ff @(posedge clk_i) begin
    master_clear_n_sync_reg <= {master_clear_n_sync_reg[1:0], master_clear_n_i};
    rc_sync_reg <= {rc_sync_reg[1:0], timer_rc_i};
    osc_sync_reg <= {osc_sync_reg[1:0], osc_pin_in_i};
    por_sync_reg <= {por_sync_reg[1:0], por_i};
    wdt_sync_reg <= {wdt_sync_reg[1:0], wdt_timeout_i};
  end

  // Agreement of stages two and three marks a settled level.
  logic rc_rise;
  logic osc_rise;
  logic por_level;
  logic wdt_rise;
  logic rc_prev_reg;
  logic osc_prev_reg;
  logic wdt_prev_reg;
  logic por_reg;

  // Reset parks the edge memories at the idle pin level, so no false edge
  // follows it, and keeps the power-on level up until the pin has settled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      wdt_prev_reg <= 1'b0;
      por_reg <= 1'b1;
    end else begin
      if (rc_sync_reg[2] == rc_sync_reg[1]) begin
        rc_prev_reg <= rc_sync_reg[2];
      end
      if (osc_sync_reg[2] == osc_sync_reg[1]) begin
        osc_prev_reg <= osc_sync_reg[2];
      end
      if (wdt_sync_reg[2] == wdt_sync_reg[1]) begin
        wdt_prev_reg <= wdt_sync_reg[2];
      end
      if (por_sync_reg[2] == por_sync_reg[1]) begin
        por_reg <= por_sync_reg[2];
      end
    end
  end

  assign rc_rise = rc_sync_reg[2] & rc_sync_reg[1] & ~rc_prev_reg;
  assign osc_rise = osc_sync_reg[2] & osc_sync_reg[1] & ~osc_prev_reg;
  assign wdt_rise = wdt_sync_reg[2] & wdt_sync_reg[1] & ~wdt_prev_reg;
  assign por_level = por_reg | rst_i; // [RULE_15]

  // Master-clear filter: a level must hold for filt_cycles before it counts.
  // Short glitches restart the count and never reach the sequencer.
  logic master_clear_n_filt_reg;
  logic [2:0] filt_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_clear_n_filt_reg <= 1'b0;
      filt_cnt_reg <= 3'h0;
    end else if ((master_clear_n_sync_reg[2] != master_clear_n_sync_reg[1])
                 || (master_clear_n_sync_reg[2] == master_clear_n_filt_reg)) begin
      filt_cnt_reg <= 3'h0; // [RULE_11]
    end else if (filt_cnt_reg == 3'(filt_cycles - 1)) begin
      master_clear_n_filt_reg <= master_clear_n_sync_reg[2]; // [RULE_11]
      filt_cnt_reg <= 3'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 3'h1;
    end
  end

  // Configuration word, fixed while the sequencer is in st_run.
  logic [4:0] cfg_reg;
  logic [2:0] osc_sel;
  logic powerup_timer_on;

  assign osc_sel = cfg_reg[osc_sel_lsb +: 3]; // [RULE_22]
  assign powerup_timer_on = ~cfg_reg[powerup_timer_en_bit]; // [RULE_21] [RULE_18]

  // Start-up sequencer.
  seq_t state_reg;
  logic [31:0] powerup_timer_cnt_reg;
  logic [10:0] ost_cnt_reg;
  logic wake_ost_reg;
  logic sleep_d_reg;
  cause_t cause_reg;

  always_ff @(posedge clk_i) begin
    if (por_level) begin
      state_reg <= st_por; // [RULE_15]
      powerup_timer_cnt_reg <= 32'h0;
      ost_cnt_reg <= 11'h0;
      wake_ost_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_por: begin
          powerup_timer_cnt_reg <= 32'h0;
          ost_cnt_reg <= 11'h0;
          state_reg <= powerup_timer_on ? st_powerup_timer : st_ost; // [RULE_18]
        end
        st_powerup_timer: begin
          // Counted on the timer's own RC edges. [RULE_17]
          if (powerup_timer_cnt_reg >= 32'(powerup_timer_count)) begin
            state_reg <= st_ost; // [RULE_16]
          end else if (rc_rise) begin
            powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 32'h1;
          end
        end
        st_ost: begin
          if (!osc_is_crystal(osc_sel)
              || ost_cnt_reg >= 11'(ost_count)) begin
            state_reg <= st_hold; // [RULE_20]
          end else if (osc_rise) begin
            ost_cnt_reg <= ost_cnt_reg + 11'h1; // [RULE_19]
          end
        end
        st_hold: begin
          if (master_clear_n_filt_reg) begin
            state_reg <= st_run; // [RULE_23]
          end
        end
        st_run: begin
          // A watchdog expiry in sleep is a wake-up and keeps the core going.
          if (!master_clear_n_filt_reg || (wdt_rise && !sleeping_i)) begin
            state_reg <= st_hold; // [RULE_23] [RULE_12]
          end else if (sleep_d_reg && !sleeping_i
                       && osc_is_crystal(osc_sel)) begin
            ost_cnt_reg <= 11'h0; // [RULE_20]
            wake_ost_reg <= 1'b1;
            state_reg <= st_ost;
          end
        end
        default: begin
          state_reg <= st_por;
        end
      endcase
      if (state_reg == st_hold) begin
        wake_ost_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    sleep_d_reg <= rst_i ? 1'b0 : sleeping_i;
  end

  // Reset cause; a watchdog expiry during sleep is a wake-up, not a reset.
  always_ff @(posedge clk_i) begin
    if (por_level) begin
      cause_reg <= cause_por; // [RULE_08]
    end else if (state_reg == st_run && !master_clear_n_filt_reg) begin
      cause_reg <= sleeping_i ? cause_master_clear_n_sleep : cause_master_clear_n_run; // [RULE_08]
    end else if (state_reg == st_run && wdt_rise) begin
      cause_reg <= sleeping_i ? cause_wdt_wake : cause_wdt_run; // [RULE_08]
    end
  end

  // Core reset output; a watchdog wake-up only raises the resume strobe.
  logic wdt_wake;
  assign wdt_wake = (state_reg == st_run) && wdt_rise && sleeping_i;

  always_ff @(posedge clk_i) begin
    if (por_level) begin
      core_reset_o <= 1'b1;
      wake_resume_o <= 1'b0;
    end else begin
      core_reset_o <= (state_reg != st_run) && !wake_ost_reg; // [RULE_10]
      wake_resume_o <= wdt_wake; // [RULE_10]
    end
  end

  // Trim register: loaded on power-on or chip reset only, kept through master-clear and
  // watchdog resets, so a calibration copied in by software survives them.
  // The cfg image stands for programming-time bits: only the chip reset
  // loads it, and a later power-on keeps it. [RULE_09]
  logic [7:0] trim_reg;
  logic bus_hit;
  logic bus_wr;

  // A write lands at the edge where the master samples ack high.
  assign bus_hit = cyc_i && stb_i && !ack_o;
  assign bus_wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (por_level) begin
      trim_reg <= trim_reset; // [RULE_09]
    end else if (bus_wr && adr_i == trim_off) begin
      // Bits 1:0 are not built; they always read as zero. [RULE_03]
      trim_reg <= dat_i[7:0] & trim_impl_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= cfg_reset; // [RULE_09]
    end else if (bus_wr && adr_i == cfg_off && state_reg != st_run) begin
      cfg_reg <= dat_i[4:0]; // [RULE_18]
    end
  end

  // Trim drives the analog RC: fine nibble steps up, coarse bits jump.
  always_ff @(posedge clk_i) begin
    trim_o <= rst_i ? trim_reset : trim_reg; // [RULE_01] [RULE_02]
  end

  // Wishbone read mux and single-cycle ack; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_hit;
      case (adr_i)
        trim_off: dat_o <= {24'h0, trim_reg};
        cfg_off: dat_o <= {27'h0, cfg_reg};
        status_off: dat_o <= {25'h0, state_reg, 1'b0, cause_reg};
        cal_off: dat_o <= {24'h0, cal_value}; // [RULE_04]
        default: dat_o <= 32'h0;
      endcase
    end
  end

  // Divide-by-four output: the system clock is taken as the oscillator.
  logic [1:0] div_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1; // [RULE_07] [RULE_05]
    end
  end

  // Pin drive: held low under master clear in clock-out modes, otherwise an
  // input. The watchdog path never touches the master-clear pin.
  pin_drv_t out_drv;
  always_comb begin
    out_drv.out_o = 1'b0;
    out_drv.oe = 1'b0;
    if (osc_is_divided_clock_output(osc_sel)) begin
      out_drv.oe = 1'b1; // [RULE_06] [RULE_13]
      out_drv.out_o = master_clear_n_filt_reg && div_reg[1]; // [RULE_07]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_pin_out_o <= 1'b0;
      osc_pin_out_oe_o <= 1'b0;
      osc_pin_in_oe_o <= 1'b0;
    end else begin
      osc_pin_out_o <= out_drv.out_o;
      osc_pin_out_oe_o <= out_drv.oe;
      osc_pin_in_oe_o <= 1'b0; // [RULE_14]
    end
  end

  // Checks.
  property p_in_pin_quiet;
    @(posedge clk_i) disable iff (rst_i) !osc_pin_in_oe_o;
  endproperty
  a_in_pin_quiet: assert property (p_in_pin_quiet) // [RULE_14]
    else $error("first pin driven");
  property p_no_divided_clock_output;
    @(posedge clk_i) disable iff (rst_i)
      !osc_is_divided_clock_output($past(osc_sel)) |-> !osc_pin_out_oe_o;
  endproperty
  a_no_divided_clock_output: assert property (p_no_divided_clock_output) // [RULE_06]
    else $error("clock out in wrong mode");
  property p_low_in_clear;
    @(posedge clk_i) disable iff (rst_i)
      !$past(master_clear_n_filt_reg) |-> !osc_pin_out_o;
  endproperty
  a_low_in_clear: assert property (p_low_in_clear) // [RULE_13]
    else $error("second pin not low under clear");
  property p_div4;
    @(posedge clk_i) disable iff (rst_i)
      $rose(div_reg[1]) |-> ##4 $rose(div_reg[1]);
  endproperty
  a_div4: assert property (p_div4) else $error("divide not by four"); // [RULE_07]
  property p_trim_low;
    @(posedge clk_i) disable iff (rst_i) trim_reg[1:0] == 2'b00;
  endproperty
  a_trim_low: assert property (p_trim_low) else $error("trim low bits set"); // [RULE_03]
  property p_run_needs_clear;
    @(posedge clk_i) disable iff (por_level)
      (state_reg == st_hold && !master_clear_n_filt_reg) |=> state_reg != st_run;
  endproperty
  a_run_needs_clear: assert property (p_run_needs_clear) // [RULE_23]
    else $error("released under clear");
  property p_por_holds;
    @(posedge clk_i) por_level |=> core_reset_o;
  endproperty
  a_por_holds: assert property (p_por_holds) else $error("por no reset"); // [RULE_15]
  property p_wake_keeps;
    @(posedge clk_i) disable iff (por_level)
      wdt_wake |=> (state_reg == st_run) && !core_reset_o;
  endproperty
  a_wake_keeps: assert property (p_wake_keeps) // [RULE_10]
    else $error("watchdog wake reset core");
  c_release: cover property (@(posedge clk_i) $fell(core_reset_o));
  c_ost: cover property (@(posedge clk_i) state_reg == st_ost ##1 state_reg == st_hold);
  c_wake: cover property (@(posedge clk_i) wdt_wake);

endmodule
`default_nettype wire

//--- testbench/reset_and_clock_startup_tb.sv
// Self-checking bench for the reset and clock start-up block.
// Assumes the Wishbone answer comes one cycle after a request is taken and
// that the two start-up counts are shortened through parameters.
`timescale 1ns/100ps
`default_nettype none

module reset_and_clock_startup_tb;
  import rst_clk_pkg::*;

  localparam int powerup_timer_short = 20;
  localparam int ost_short = 8;
  localparam logic [7:0] cal_test = 8'h3c; // Arbitrary factory value.
  localparam int cycle_limit = 20000;

  // Bench-driven inputs, all defined from time zero.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic por_i = 1'b0, wdt_timeout_i = 1'b0, sleeping_i = 1'b0;
  logic master_clear_n_i = 1'b0, timer_rc_i = 1'b0, osc_pin_in_i = 1'b0;
  // Design outputs.
  logic [31:0] dat_o;
  logic [7:0] trim_o;
  logic ack_o, osc_pin_in_oe_o, osc_pin_out_o, osc_pin_out_oe_o;
  logic core_reset_o, wake_resume_o;
  // Bench bookkeeping.
  logic rc_run = 1'b0, osc_run = 1'b0;
  logic [1:0] ph = 2'h0;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int k;
  logic [31:0] rdata;
  logic a0, seen_wake, seen_rst;
  logic [4:0] cfg_tab [3] = '{5'h01, 5'h05, 5'h15};
  logic s1_tab [3] = '{1'b1, 1'b1, 1'b0};
  logic s2_tab [3] = '{1'b1, 1'b0, 1'b0};

  reset_and_clock_startup #(
    .powerup_timer_count(powerup_timer_short),
    .ost_count(ost_short),
    .cal_value(cal_test)
  ) i_reset_and_clock_startup (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .por_i(por_i),
    .master_clear_n_i(master_clear_n_i), .wdt_timeout_i(wdt_timeout_i),
    .sleeping_i(sleeping_i), .timer_rc_i(timer_rc_i),
    .osc_pin_in_i(osc_pin_in_i), .osc_pin_in_oe_o(osc_pin_in_oe_o),
    .osc_pin_out_o(osc_pin_out_o), .osc_pin_out_oe_o(osc_pin_out_oe_o),
    .core_reset_o(core_reset_o), .trim_o(trim_o),
    .wake_resume_o(wake_resume_o)
  );

  // Core clock, 10 ns period.
  always #5 clk_i = !clk_i;

  // Timer edge sources and the hang guard; an edge only every three cycles
  // lets the synchronisers see each level before it flips.
  always @(posedge clk_i) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h0 && rc_run) begin
      timer_rc_i <= !timer_rc_i;
    end
    if (ph == 2'h0 && osc_run) begin
      osc_pin_in_i <= !osc_pin_in_i;
    end
    cycles <= cycles + 1;
    if (cycles == cycle_limit) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] want,
                     input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== want) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask

  // One classic Wishbone cycle; the request stands until ack is sampled.
  task automatic xfer(input logic we, input logic [3:0] adr,
                      input logic [7:0] wd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    sel_i <= 4'h1;
    dat_i <= {24'h0, wd};
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [31:0] mask,
                    input logic [31:0] want, input string what);
    xfer(1'b0, adr, 8'h00);
    chk(what, want, rdata & mask);
  endtask

  // Bounded wait for the core reset to reach a level.
  task automatic wait_core(input logic want, input int limit);
    int n;
    n = 0;
    while (core_reset_o !== want && n < limit) begin
      @(posedge clk_i);
      n++;
    end
    chk("core_reset_o", 32'(want), 32'(core_reset_o));
  endtask

  task automatic hold_core(input logic want, input int len);
    logic seen;
    seen = want;
    repeat (len) begin
      @(posedge clk_i);
      if (core_reset_o !== want) seen = core_reset_o;
    end
    chk("core_reset_o held", 32'(want), 32'(seen));
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(trim_off, 32'hff, 32'h70, "trim reset");
    chk("trim_o", 32'h70, 32'(trim_o));
    rd(cfg_off, 32'h1f, 32'h1d, "cfg reset");
    rd(cal_off, 32'hff, 32'(cal_test), "calibration");
    xfer(1'b1, cal_off, 8'hff);
    rd(cal_off, 32'hff, 32'(cal_test), "calibration kept");
    rd(4'h2, 32'hffffffff, 32'h0, "unmapped read");
    rd(status_off, 32'h7, 32'(cause_por), "cause");
    // Power-up: crystal with both timers, RC with the power-up timer,
    // RC with the power-up timer switched off.
    for (k = 0; k < 3; k++) begin
      master_clear_n_i <= 1'b0;
      wait_core(1'b1, 40);
      xfer(1'b1, cfg_off, {3'h0, cfg_tab[k]});
      rd(cfg_off, 32'h1f, 32'(cfg_tab[k]), "cfg");
      por_i <= 1'b1;
      master_clear_n_i <= 1'b1;
      hold_core(1'b1, 10);
      por_i <= 1'b0;
      repeat (200) @(posedge clk_i);
      chk("core no edges", 32'(s1_tab[k]), 32'(core_reset_o));
      rc_run <= 1'b1;
      repeat (300) @(posedge clk_i);
      rc_run <= 1'b0;
      chk("core rc edges", 32'(s2_tab[k]), 32'(core_reset_o));
      osc_run <= 1'b1;
      wait_core(1'b0, 300);
      osc_run <= 1'b0;
      rd(status_off, 32'h7, 32'(cause_por), "cause");
    end
    // Master clear in run, then pin states in every RC pin mode.
    master_clear_n_i <= 1'b0;
    wait_core(1'b1, 40);
    rd(status_off, 32'h7, 32'(cause_master_clear_n_run), "cause");
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, cfg_off, 8'h1c + k[7:0]);
      repeat (3) @(posedge clk_i);
      chk("out pin oe", 32'(k[0]), 32'(osc_pin_out_oe_o));
      chk("out pin low", 32'h0, 32'(osc_pin_out_o & k[0]));
      chk("in pin oe", 32'h0, 32'(osc_pin_in_oe_o));
    end
    master_clear_n_i <= 1'b1;
    wait_core(1'b0, 40);
    xfer(1'b1, trim_off, 8'ha4);
    rd(trim_off, 32'hff, 32'ha4, "trim");
    chk("trim_o", 32'ha4, 32'(trim_o));
    xfer(1'b1, cfg_off, 8'h01);
    rd(cfg_off, 32'h1f, 32'h1f, "cfg locked");
    // Divided clock: two core cycles each half period.
    a0 = osc_pin_out_o;
    repeat (2) @(posedge clk_i);
    chk("clock out half", 32'(!a0), 32'(osc_pin_out_o));
    repeat (2) @(posedge clk_i);
    chk("clock out period", 32'(a0), 32'(osc_pin_out_o));
    chk("clock out oe", 32'h1, 32'(osc_pin_out_oe_o));
    // A two-cycle glitch on the pin must not reset the core.
    master_clear_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    master_clear_n_i <= 1'b1;
    hold_core(1'b0, 20);
    // Master clear during sleep; the trim value survives it.
    sleeping_i <= 1'b1;
    master_clear_n_i <= 1'b0;
    wait_core(1'b1, 40);
    sleeping_i <= 1'b0;
    master_clear_n_i <= 1'b1;
    wait_core(1'b0, 40);
    rd(status_off, 32'h7, 32'(cause_master_clear_n_sleep), "cause");
    rd(trim_off, 32'hff, 32'ha4, "trim kept");
    // Watchdog reset in run.
    wdt_timeout_i <= 1'b1;
    wait_core(1'b1, 40);
    wdt_timeout_i <= 1'b0;
    wait_core(1'b0, 40);
    rd(status_off, 32'h7, 32'(cause_wdt_run), "cause");
    // Watchdog wake from sleep resumes without a core reset.
    sleeping_i <= 1'b1;
    wdt_timeout_i <= 1'b1;
    seen_wake = 1'b0;
    seen_rst = 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      seen_wake = seen_wake | (wake_resume_o === 1'b1);
      seen_rst = seen_rst | (core_reset_o !== 1'b0);
    end
    wdt_timeout_i <= 1'b0;
    sleeping_i <= 1'b0;
    chk("wake pulse", 32'h1, 32'(seen_wake));
    chk("reset on wake", 32'h0, 32'(seen_rst));
    rd(status_off, 32'h7, 32'(cause_wdt_wake), "cause");
    rd(trim_off, 32'hff, 32'ha4, "trim kept");
    // Wake-up in a crystal mode reruns the start-up timer, core kept going.
    master_clear_n_i <= 1'b0;
    wait_core(1'b1, 40);
    xfer(1'b1, cfg_off, 8'h01);
    master_clear_n_i <= 1'b1;
    wait_core(1'b0, 40);
    sleeping_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sleeping_i <= 1'b0;
    rd(status_off, 32'h70, 32'h20, "wake start-up");
    osc_run <= 1'b1;
    hold_core(1'b0, 100);
    osc_run <= 1'b0;
    rd(status_off, 32'h70, 32'h40, "resumed");
    end_sim();
  end

endmodule
`default_nettype wire
